//--- src/card_eeprom_command_exec.sv
// byte fifo and command executor of a 256-byte chip-card memory
// assumes card_clk, card_rst and io_in come straight from pins
`timescale 1ns/100ps

module card_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("fifo depth must be a power of two");
        end
    endgenerate

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data  = mem_q[rd_q[AW-1:0]];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_q <= '0;
            rd_q <= '0;
        end else if (flush) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

endmodule : card_byte_fifo

module card_eeprom_command_exec
    import card_cmd_pkg::*;
#(
    parameter int          FIFO_DEPTH = 4,
    // arbitrary neutral code value
    parameter logic [23:0] PSC_INIT   = 24'h000000
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic card_clk,
    input  wire logic card_rst,
    input  wire logic io_in,
    output logic      io_out,
    output logic      io_oe,
    input  wire logic code_verified
);
    function automatic logic [8:0] prog_pulses(input logic [7:0] old_b,
                                               input logic [7:0] new_b);
        logic need_erase;
        logic need_write;
        need_erase = |(~old_b & new_b);
        need_write = need_erase ? (new_b != ERASED_BYTE) : (old_b != new_b);
        prog_pulses = (need_erase && need_write) ? 9'(DOUBLE_PULSES) // [R6] [R7]
                                                 : 9'(STEP_PULSES);
    endfunction : prog_pulses

    logic [1:0]  clk_sync_q;
    logic [1:0]  io_sync_q;
    logic [1:0]  rst_sync_q;
    logic        clk_prev_q;
    logic        io_prev_q;
    logic        clk_rise;
    logic        clk_fall;
    logic        start_cond;
    logic        stop_cond;
    logic        brk;
    state_t      state_q;
    logic [23:0] frame_q;
    logic [4:0]  pulse_q;
    logic [11:0] out_left_q;
    logic [2:0]  bit_idx_q;
    logic [7:0]  shift_q;
    logic [8:0]  proc_cnt_q;
    logic [8:0]  proc_len_q;
    logic [7:0]  addr_q;
    logic [7:0]  data_q;
    logic        write_main_q;
    logic        write_prot_q;
    logic        io_oe_q;
    logic        fetch_on_q;
    src_t        src_q;
    logic [7:0]  fetch_idx_q;
    logic [7:0]  fetch_end_q;
    logic [7:0]  fetch_byte;
    logic [7:0]  main_q [MAIN_BYTES];
    logic [PROT_BITS-1:0] prot_q;
    logic [7:0]  counter_q;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_pop;
    logic [7:0]  fifo_out_data;
    logic [7:0]  f_ctl;
    logic [7:0]  f_addr;
    logic [7:0]  f_data;
    logic        f_low;
    logic        prot_hit;
    logic        frame_ok;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clk_sync_q <= 2'h0;
            io_sync_q  <= 2'h3;
            rst_sync_q <= 2'h0;
            clk_prev_q <= 1'b0;
            io_prev_q  <= 1'b1;
        end else begin
            clk_sync_q <= {clk_sync_q[0], card_clk};
            io_sync_q  <= {io_sync_q[0], io_in};
            rst_sync_q <= {rst_sync_q[0], card_rst};
            clk_prev_q <= clk_sync_q[1];
            io_prev_q  <= io_sync_q[1];
        end
    end

    assign clk_rise   = clk_sync_q[1] & ~clk_prev_q;
    assign clk_fall   = ~clk_sync_q[1] & clk_prev_q;
    assign start_cond = clk_sync_q[1] & clk_prev_q & io_prev_q & ~io_sync_q[1];
    assign stop_cond  = clk_sync_q[1] & clk_prev_q & ~io_prev_q & io_sync_q[1];
    assign brk        = rst_sync_q[1];
    assign f_ctl    = frame_q[7:0];
    assign f_addr   = frame_q[15:8];
    assign f_data   = frame_q[23:16];
    assign f_low    = f_addr < 8'(PROT_BITS); // [R14] [R23]
    assign prot_hit = f_low & prot_q[f_addr[4:0]];
    assign frame_ok = pulse_q == 5'(FRAME_PULSES);

    // mode sequencing and io drive
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q      <= ST_IDLE;
            pulse_q      <= '0;
            out_left_q   <= '0;
            proc_cnt_q   <= '0;
            proc_len_q   <= '0;
            addr_q       <= '0;
            data_q       <= '0;
            write_main_q <= 1'b0;
            write_prot_q <= 1'b0;
            io_oe_q      <= 1'b0;
        end else if (brk) begin
            state_q <= ST_IDLE;
            io_oe_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (start_cond) begin
                        state_q <= ST_CMD;
                        pulse_q <= '0;
                    end
                end
                ST_CMD: begin
                    if (start_cond) begin
                        pulse_q <= '0;
                    end else if (clk_rise && pulse_q != 5'h1F) begin
                        pulse_q <= pulse_q + 1'b1;
                    end else if (stop_cond) begin
                        state_q    <= ST_IDLE;
                        addr_q     <= f_addr;
                        data_q     <= f_data;
                        proc_cnt_q <= '0;
                        if (frame_ok) begin // [R19]
                            unique case (f_ctl)
                                CMD_READ_MAIN: begin // [R1] [R21]
                                    state_q    <= ST_OUT;
                                    out_left_q <= 12'((MAIN_BYTES - int'(f_addr)) * 8);
                                end
                                CMD_READ_PROT, CMD_READ_SEC: begin // [R3] [R4] [R16]
                                    state_q    <= ST_OUT;
                                    out_left_q <= 12'(READ32_BITS);
                                end
                                CMD_UPDATE_MAIN: begin // [R8] [R22]
                                    state_q      <= ST_PROC;
                                    write_prot_q <= 1'b0;
                                    write_main_q <= ~prot_hit & code_verified;
                                    proc_len_q <= (prot_hit || !code_verified) ? // [R9] [R23]
                                                  9'(BLOCKED_PULSES) :
                                                  prog_pulses(main_q[f_addr], f_data);
                                end
                                CMD_WRITE_PROT: begin // [R13] [R24]
                                    state_q      <= ST_PROC;
                                    write_main_q <= 1'b0;
                                    if (f_low && !prot_hit && code_verified &&
                                        main_q[f_addr] == f_data) begin // [R10]
                                        write_prot_q <= 1'b1;
                                        proc_len_q   <= 9'(STEP_PULSES); // [R12]
                                    end else begin // [R11]
                                        write_prot_q <= 1'b0;
                                        proc_len_q   <= 9'(BLOCKED_PULSES);
                                    end
                                end
                                default: state_q <= ST_IDLE;
                            endcase
                        end
                    end
                end
                ST_OUT: begin
                    if (clk_fall) begin
                        if (out_left_q == '0) begin // [R2] [R16]
                            io_oe_q <= 1'b0;
                            state_q <= ST_IDLE;
                        end else begin
                            out_left_q <= out_left_q - 1'b1;
                            io_oe_q    <= (bit_idx_q == '0) ? ~fifo_out_data[0] : ~shift_q[0];
                        end
                    end
                end
                ST_PROC: begin
                    if (clk_fall) begin
                        if (proc_cnt_q == '0) begin // [R20]
                            io_oe_q    <= 1'b1;
                            proc_cnt_q <= 9'h001;
                        end else if (proc_cnt_q == proc_len_q) begin // [R7] [R9]
                            io_oe_q <= 1'b0;
                            state_q <= ST_IDLE;
                        end else begin
                            proc_cnt_q <= proc_cnt_q + 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // command frame shift, lsb first
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frame_q <= '0;
        end else if (state_q == ST_CMD && clk_rise && !start_cond &&
                     pulse_q < 5'(FRAME_BITS)) begin
            frame_q <= {io_sync_q[1], frame_q[23:1]}; // [R19]
        end
    end

    // output serializer
    assign fifo_pop = state_q == ST_OUT && !brk && clk_fall &&
                      out_left_q != '0 && bit_idx_q == '0;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bit_idx_q <= '0;
            shift_q   <= '0;
        end else if (state_q != ST_OUT || brk) begin
            bit_idx_q <= '0;
        end else if (clk_fall && out_left_q != '0) begin
            bit_idx_q <= bit_idx_q + 1'b1;
            shift_q   <= {1'b0, (bit_idx_q == '0) ? fifo_out_data[7:1] : shift_q[7:1]};
        end
    end

    // byte fetcher feeding the fifo
    always_comb begin
        fetch_byte = '0;
        unique case (src_q)
            SRC_MAIN: fetch_byte = main_q[fetch_idx_q];
            SRC_PROT: fetch_byte = prot_q[fetch_idx_q[1:0]*8 +: 8];
            SRC_SEC: begin // [R15] [R18]
                if (fetch_idx_q[1:0] == 2'h0) begin
                    fetch_byte = counter_q;
                end else if (code_verified) begin
                    fetch_byte = PSC_INIT[(fetch_idx_q[1:0]-2'h1)*8 +: 8];
                end else begin
                    fetch_byte = 8'h00; // [R17]
                end
            end
            default: fetch_byte = '0;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fetch_on_q  <= 1'b0;
            src_q       <= SRC_MAIN;
            fetch_idx_q <= '0;
            fetch_end_q <= '0;
        end else if (brk) begin
            fetch_on_q <= 1'b0;
        end else if (state_q == ST_CMD && stop_cond && frame_ok &&
                     (f_ctl == CMD_READ_MAIN || f_ctl == CMD_READ_PROT ||
                      f_ctl == CMD_READ_SEC)) begin
            fetch_on_q  <= 1'b1;
            src_q       <= (f_ctl == CMD_READ_MAIN) ? SRC_MAIN :
                           (f_ctl == CMD_READ_PROT) ? SRC_PROT : SRC_SEC;
            fetch_idx_q <= (f_ctl == CMD_READ_MAIN) ? f_addr : 8'h00;
            fetch_end_q <= (f_ctl == CMD_READ_MAIN) ? 8'(MAIN_BYTES - 1) : 8'(SEC_BYTES - 1);
        end else if (fetch_on_q && fifo_in_ready) begin
            fetch_idx_q <= fetch_idx_q + 1'b1;
            if (fetch_idx_q == fetch_end_q) begin
                fetch_on_q <= 1'b0;
            end
        end
    end

    card_byte_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .flush     (brk),
        .in_valid  (fetch_on_q),
        .in_ready  (fifo_in_ready),
        .in_data   (fetch_byte),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    // memory commit at the end of processing
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < MAIN_BYTES; i++) begin
                main_q[i] <= MAIN_RESET;
            end
            prot_q    <= '0;
            counter_q <= COUNTER_RESET;
        end else if (state_q == ST_PROC && !brk && clk_fall &&
                     proc_cnt_q != '0 && proc_cnt_q == proc_len_q) begin
            if (write_main_q) begin
                main_q[addr_q] <= data_q; // [R5]
            end
            if (write_prot_q) begin
                prot_q[addr_q[4:0]] <= 1'b1; // [R10]
            end
        end
    end

    assign io_out = 1'b0;
    assign io_oe  = io_oe_q;

endmodule : card_eeprom_command_exec

//--- src/card_cmd_pkg.sv
// constants and types for the card memory command executor
// assumes a reader-driven link clock far slower than clk
//
// Contract
// R1: 30h reads main memory from any address
// R2: protection read: 32 bits, then release
// R3: protection read always served
// R4: 34h protection read ignores address and data
// R5: update programs addressed byte with data
// R6: erase+write, write only or erase only
// R7: single step 124 pulses, combined longer
// R8: 38h update: address then data byte
// R9: protected byte untouched, release after pulse 2
// R10: protection write programs bit on match
// R11: mismatch suppresses protection bit write
// R12: protection write timed like update
// R13: 3Ch protection write, addresses 00..1F
// R14: protection bits guard addresses 0..31 only
// R15: security bytes leave in ascending order
// R16: security read 32 pulses, then release
// R17: reference bytes read low until verified
// R18: security byte 0 counter, 1..3 code
// R19: framed 24 bits LSB first plus pulse
// R20: processing holds line low until done
// R21: main read streams to end of memory
// R22: writes need verified code
// R23: addresses above 31 never protected
// R24: protection write above 31 does nothing
package card_cmd_pkg;

    localparam logic [7:0] CMD_READ_MAIN   = 8'h30;
    localparam logic [7:0] CMD_READ_PROT   = 8'h34;
    localparam logic [7:0] CMD_UPDATE_MAIN = 8'h38;
    localparam logic [7:0] CMD_WRITE_PROT  = 8'h3C;
    localparam logic [7:0] CMD_READ_SEC    = 8'h31;

    localparam int MAIN_BYTES   = 256;
    localparam int PROT_BITS    = 32;
    localparam int SEC_BYTES    = 4;
    localparam int FRAME_BITS   = 24;
    localparam int FRAME_PULSES = 25;
    localparam int READ32_BITS  = 32;

    localparam int LINK_KHZ       = 50;
    localparam int T_STEP_US      = 2500;
    localparam int T_DOUBLE_US    = 5000;
    localparam int STEP_PULSES    = 124;
    localparam int DOUBLE_PULSES  = STEP_PULSES * T_DOUBLE_US / T_STEP_US;
    localparam int BLOCKED_PULSES = 2;

    localparam logic [7:0] MAIN_RESET    = 8'hFF;
    localparam logic [7:0] COUNTER_RESET = 8'h07;
    localparam logic [7:0] ERASED_BYTE   = 8'hFF;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CMD  = 4'b0010,
        ST_OUT  = 4'b0100,
        ST_PROC = 4'b1000
    } state_t;

    typedef enum logic [1:0] {
        SRC_MAIN = 2'h0,
        SRC_PROT = 2'h1,
        SRC_SEC  = 2'h2
    } src_t;

endpackage : card_cmd_pkg

//--- tb/card_exec_chk.sv
// pin-level assertions for the card command executor
// assumes io_in is the resolved open-drain line fed back by the bench
`timescale 1ns/100ps

module card_exec_chk
    import card_cmd_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic card_clk,
    input wire logic card_rst,
    input wire logic io_in,
    input wire logic io_out,
    input wire logic io_oe,
    input wire logic code_verified
);
    logic       ck_q;
    logic       io_q;
    logic       in_frame;
    logic       quiet;
    logic [5:0] rises;
    logic [7:0] ctrl;
    logic [3:0] since_fall;
    logic [3:0] since_rst;
    wire start_ev = card_clk && ck_q && io_q && !io_in && !io_oe;
    wire stop_ev  = card_clk && ck_q && !io_q && io_in && in_frame;
    wire rise_ev  = card_clk && !ck_q && in_frame;
    wire known    = ctrl inside {CMD_READ_MAIN, CMD_READ_PROT, CMD_READ_SEC,
                                 CMD_UPDATE_MAIN, CMD_WRITE_PROT};
    wire writes   = ctrl == CMD_UPDATE_MAIN || ctrl == CMD_WRITE_PROT;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ck_q <= 1'b0;
            io_q <= 1'b1;
        end else begin
            ck_q <= card_clk;
            io_q <= io_in;
        end
    end

    // frame tracking: start, rises, control byte, stop
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            in_frame <= 1'b0;
            quiet    <= 1'b0;
            rises    <= 6'h00;
            ctrl     <= 8'h00;
        end else if (card_rst) begin
            in_frame <= 1'b0;
            quiet    <= 1'b0;
        end else if (start_ev) begin
            in_frame <= 1'b1;
            quiet    <= 1'b0;
            rises    <= 6'h00;
        end else if (stop_ev) begin
            in_frame <= 1'b0;
            quiet    <= !(known && rises == 6'd25);
        end else if (rise_ev) begin
            rises <= rises + 6'h01;
            if (rises < 6'd8) ctrl[rises[2:0]] <= io_in;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) since_fall <= 4'h0;
        else if (!card_clk && ck_q) since_fall <= 4'h0;
        else if (since_fall != 4'hF) since_fall <= since_fall + 4'h1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) since_rst <= 4'h0;
        else if (card_rst) since_rst <= 4'h0;
        else if (since_rst != 4'hF) since_rst <= since_rst + 4'h1;
    end

    out_low_a: assert property (io_out == 1'b0)
        else $error("io_out not low");
    drive_fall_a: assert property ($rose(io_oe) |-> since_fall <= 4'd6)
        else $error("line pulled low away from a clock fall");
    release_fall_a: assert property (
        $fell(io_oe) |-> since_fall <= 4'd6 || since_rst <= 4'd6)
        else $error("line released away from a clock fall or break");
    break_release_a: assert property (card_rst [*5] |=> !io_oe)
        else $error("line still pulled during break");
    hold_cell_a: assert property ($rose(io_oe) && !card_rst |-> io_oe [*6])
        else $error("low level shorter than one bit cell");
    frame_quiet_a: assert property (in_frame |-> !io_oe)
        else $error("line pulled during command entry");
    bad_cmd_quiet_a: assert property (quiet |-> !io_oe)
        else $error("line pulled after a refused command");
    proc_low_a: assert property (
        stop_ev && rises == 6'd25 && writes |-> ##[1:16] io_oe)
        else $error("processing did not pull the line low");
endmodule : card_exec_chk

bind card_eeprom_command_exec card_exec_chk u_chk (
    .clk          (clk),
    .rstn         (rstn),
    .card_clk     (card_clk),
    .card_rst     (card_rst),
    .io_in        (io_in),
    .io_out       (io_out),
    .io_oe        (io_oe),
    .code_verified(code_verified)
);

//--- tb/card_reader_model.sv
// reader side of the card link: clock, break and open-drain data line
// assumes a pull-up on the line; clock idles low outside frames
`timescale 1ns/100ps

module card_reader_model import card_cmd_pkg::*; (
    output logic      card_clk,
    output logic      card_rst,
    input  wire logic io_oe,
    output logic      io_line
);
    logic rd_low;

    assign io_line = (io_oe || rd_low) ? 1'b0 : 1'b1;

    initial begin
        card_clk = 1'b0;
        card_rst = 1'b0;
        rd_low   = 1'b0;
    end

    // one 200 ns pulse; line sampled mid-high, next drive set mid-low
    task automatic pulse(input logic drv, output logic b);
        card_clk = 1'b1;
        #50;
        b = io_line;
        #50;
        card_clk = 1'b0;
        #50;
        rd_low = drv;
        #50;
    endtask : pulse

    // start, 24 bits lsb first, extra pulse carrying the stop, first fall
    task automatic frame(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d);
        logic [23:0] f;
        logic        b;
        f = {d, a, c};
        card_clk = 1'b1;
        #50;
        rd_low = 1'b1;
        #50;
        card_clk = 1'b0;
        #50;
        rd_low = !f[0];
        #50;
        for (int i = 0; i < FRAME_BITS; i++) begin
            pulse((i < FRAME_BITS - 1) ? !f[i + 1] : 1'b1, b);
        end
        card_clk = 1'b1;
        #50;
        rd_low = 1'b0;
        #50;
        card_clk = 1'b0;
        #100;
    endtask : frame

    task automatic brk();
        card_rst = 1'b1;
        #1000;
        card_rst = 1'b0;
        #200;
    endtask : brk
endmodule : card_reader_model

//--- tb/tb_card_eeprom_command_exec.sv
// self-checking bench of the card command executor against a memory model
// assumes the reader model drives the link; design inputs move 2 ns after clk
`timescale 1ns/100ps

module tb_card_eeprom_command_exec import card_cmd_pkg::*; ;
    // repeated byte so the code byte order does not matter
    localparam logic [23:0] CODE = 24'h5A5A5A;
    logic        clk;
    logic        rstn;
    logic        code_verified;
    logic        card_clk;
    logic        card_rst;
    logic        io_line;
    logic        io_out;
    logic        io_oe;
    logic        b;
    int          fail_count;
    int          compares;
    logic [31:0] seed;
    logic [7:0]  mem [MAIN_BYTES];
    logic [31:0] prot;
    logic [7:0]  seq [4] = '{8'hAA, 8'h55, 8'hFF, 8'hFF};

    card_eeprom_command_exec #(.FIFO_DEPTH(4), .PSC_INIT(CODE)) dut (
        .clk(clk), .rstn(rstn), .card_clk(card_clk), .card_rst(card_rst),
        .io_in(io_line), .io_out(io_out), .io_oe(io_oe), .code_verified(code_verified)
    );
    card_reader_model rdr (
        .card_clk(card_clk), .card_rst(card_rst), .io_oe(io_oe), .io_line(io_line)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task automatic set_ver(input logic v);
        @(posedge clk);
        #2;
        code_verified = v;
    endtask : set_ver

    // write command, model effect, count low pulses until release
    task automatic upd(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d);
        int          e;
        logic [15:0] n;
        if (!code_verified || (c == CMD_UPDATE_MAIN ? (a < 32 && prot[a[4:0]])
                               : (a > 31 || prot[a[4:0]] || mem[a] !== d))) begin
            e = BLOCKED_PULSES;
        end else if (c == CMD_WRITE_PROT) begin
            e = STEP_PULSES;
            prot[a[4:0]] = 1'b1;
        end else begin
            e = ((~mem[a] & d) != 8'h00 && d != ERASED_BYTE) ? DOUBLE_PULSES : STEP_PULSES;
            mem[a] = d;
        end
        rdr.frame(c, a, d);
        n = 16'h0000;
        rdr.pulse(1'b0, b);
        while (b === 1'b0 && n < 16'd300) begin
            n++;
            rdr.pulse(1'b0, b);
        end
        chk(n, e[15:0], "processing pulses");
    endtask : upd

    // read command, bytes lsb first against the model, then release
    task automatic rd(input logic [7:0] c, input logic [7:0] a);
        logic [7:0] g;
        logic [7:0] x;
        int         n;
        n = (c == CMD_READ_MAIN) ? MAIN_BYTES - a : SEC_BYTES;
        rdr.frame(c, a, ~a);
        for (int i = 0; i < n; i++) begin
            for (int k = 0; k < 8; k++) begin
                rdr.pulse(1'b0, b);
                g[k] = b;
            end
            if (c == CMD_READ_MAIN) x = mem[a + i];
            else if (c == CMD_READ_PROT) x = prot[i * 8 +: 8];
            else x = (i == 0) ? COUNTER_RESET : (code_verified ? CODE[7:0] : 8'h00);
            chk({8'h00, g}, {8'h00, x}, "read byte");
        end
        rdr.pulse(1'b0, b);
        chk(16'(b), 16'h0001, "release after read");
    endtask : rd

    initial begin
        #2_000_000;
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        close_out();
    end

    initial begin
        rstn = 1'b0;
        code_verified = 1'b0;
        fail_count = 0;
        compares = 0;
        seed = 32'h96D0086E;
        prot = 32'h0000_0000;
        for (int i = 0; i < MAIN_BYTES; i++) mem[i] = MAIN_RESET;
        repeat (3) @(posedge clk);
        #2;
        rstn = 1'b1;
        repeat (8) @(posedge clk);
        #2;
        chk(16'(io_oe), 16'h0000, "released after reset");
        rd(CMD_READ_SEC, 8'h00);
        upd(CMD_UPDATE_MAIN, 8'h05, 8'hAA);
        $display("test locked access done");
        set_ver(1'b1);
        rd(CMD_READ_SEC, 8'h00);
        foreach (seq[i]) upd(CMD_UPDATE_MAIN, 8'h05, seq[i]);
        repeat (4) begin
            seed = lfsr(seed);
            upd(CMD_UPDATE_MAIN, seed[7:0], seed[15:8]);
        end
        $display("test updates done");
        upd(CMD_WRITE_PROT, 8'h05, ~mem[5]);
        upd(CMD_WRITE_PROT, 8'h05, mem[5]);
        upd(CMD_WRITE_PROT, 8'h05, mem[5]);
        upd(CMD_UPDATE_MAIN, 8'h05, 8'h12);
        upd(CMD_WRITE_PROT, 8'h1F, mem[31]);
        upd(CMD_WRITE_PROT, 8'h28, mem[40]);
        upd(CMD_UPDATE_MAIN, 8'h28, 8'h3C);
        seed = lfsr(seed);
        rd(CMD_READ_PROT, seed[7:0]);
        $display("test protection done");
        rd(CMD_READ_MAIN, 8'h00);
        rd(CMD_READ_MAIN, 8'hFF);
        rd(CMD_READ_MAIN, 8'hE0 | seed[15:8]);
        $display("test main reads done");
        rdr.frame(8'h35, 8'h00, 8'h00);
        repeat (4) begin
            rdr.pulse(1'b0, b);
            chk(16'(b), 16'h0001, "unknown command");
        end
        $display("test unknown command done");
        rdr.frame(CMD_UPDATE_MAIN, 8'hF0, ~mem[240]);
        repeat (10) rdr.pulse(1'b0, b);
        rdr.brk();
        chk(16'(io_line), 16'h0001, "release on break");
        rd(CMD_READ_MAIN, 8'hF0);
        $display("test break done");
        close_out();
    end
endmodule : tb_card_eeprom_command_exec
